// file: rtl/fbp_pkg.sv
// constants, states and register map of the flash block protection logic
package fbp_pkg;

    // array geometry: 32 KB as 8192 words, 2 KB protection blocks
    localparam int          WORD_AW       = 13;
    localparam int          NUM_BLK       = 16;
    localparam int          BLK_LSB       = 9;   // word index bit of the 2 KB block
    localparam int          PAGE_LSB      = 8;   // word index bit of the 1 KB erase page

    // register byte addresses
    localparam logic [8:0]  OFS_FMA       = 9'h000;
    localparam logic [8:0]  OFS_FMD       = 9'h004;
    localparam logic [8:0]  OFS_FMC       = 9'h008;
    localparam logic [8:0]  OFS_RIS       = 9'h00C;
    localparam logic [8:0]  OFS_IMASK     = 9'h010;
    localparam logic [8:0]  OFS_MISC      = 9'h014;
    localparam logic [8:0]  OFS_RE        = 9'h130;
    localparam logic [8:0]  OFS_PE        = 9'h134;
    localparam logic [8:0]  OFS_USEC      = 9'h140;

    // flash control register layout
    localparam logic [15:0] FMC_KEY       = 16'hA442;
    localparam int          FMC_WRITE_BIT = 0;
    localparam int          FMC_ERASE_BIT = 1;
    localparam int          FMC_COMMIT_REQUEST_BIT_BIT  = 3;

    // status and mask bit positions
    localparam int          ST_VIOL_BIT   = 0;
    localparam int          ST_DONE_BIT   = 1;

    // debug port enable field
    localparam int          DBG_LSB       = 30;
    localparam logic [1:0]  DBG_EN        = 2'h2;

    // address that selects the debug and execute-only commit
    localparam logic [14:0] DBG_COMMIT_ADR = 15'h0900;

    // values after reset
    localparam logic [15:0] BLK_FACTORY   = 16'hFFFF;
    localparam logic [1:0]  DBG_FACTORY   = 2'h2;
    localparam logic [7:0]  USEC_RST      = 8'h31;

    // operation lengths in microseconds
    localparam logic [15:0] PROG_US       = 16'h0014;
    localparam logic [15:0] ERASE_US      = 16'h0014;
    localparam logic [15:0] COMMIT_US     = 16'h0014;

    // controller states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_RDOLD  = 5'b00010,
        ST_PROG   = 5'b00100,
        ST_ERASE  = 5'b01000,
        ST_COMMIT = 5'b10000
    } fbp_state_e;

endpackage

// file: rtl/fbp_flash_protect.sv
// flash access policy, program/erase sequencing and protection commit logic
//
// Added by the designer: the address-and-strobe port and the register addresses.

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: erase works on 1 KB pages and sets every bit of the page to one.
// R2: program writes one 32-bit word and only turns ones into zeros.
// R3: protection works on 2 KB blocks, each pair of pages with own bits.
// R4: program-enable and read-enable bits live in two 32-bit registers.
// R5: program-enable one allows program and erase; zero leaves the block unchanged.
// R6: read-enable zero allows only instruction fetch, no data or debugger reads.
// R7: read enabled, program disabled means read-only: program and erase refused.
// R8: both bits zero means execute-only: fetch only, program and erase refused.
// R9: refused program or erase flags a violation, interrupt when masked in.
// R10: blocked data read returns zeros and flags a violation.
// R11: unprogrammed parts have every policy bit at one.
// R12: policy writes act at once but stay volatile until committed.
// R13: uncommitted cleared bits return to committed value on power-on reset.
// R14: debug field value two enables the debug access port, cleared disables it.
// R15: a committed cleared debug field can never be enabled again.
// R16: committed debug disable takes effect only from the next power-up.
// R17: only the debug access port is blocked; the test access port stays usable.
// R18: software writes execute-only bits together with the debug disable bits.
// R19: operation timing counts microseconds from the cycles-per-microsecond value.
// R20: timing value resets to suit maximum clock; software reloads after changes.
// R21: address bit 0 selects program-enable (1) or read-enable (0) commit.
// R22: address 0x900 then commit bit commits debug field and execute-only bits.
// R23: commit bit reads set while the commit runs and clears on completion.
// R24: power-on reset loads working bits from committed copies before any access.
module fbp_flash_protect (
    // clock, power-on reset and factory initialisation of the nonvolatile copies
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        factory_rst_n_i,
    // register port
    input  wire logic [8:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // processor and debugger read path
    input  wire logic        rd_req_i,
    input  wire logic        rd_fetch_i,
    input  wire logic [12:0] rd_addr_i,
    output logic             rd_ready_o,
    output logic             rd_valid_o,
    output logic      [31:0] rd_data_o,
    // flash array
    output logic             arr_rd_o,
    output logic             arr_wr_o,
    output logic             arr_erase_o,
    output logic      [12:0] arr_addr_o,
    output logic      [31:0] arr_wdata_o,
    input  wire logic [31:0] arr_rdata_i,
    // status
    output logic             irq_o,
    output logic             dap_en_o
);

    fbp_pkg::fbp_state_e state_q;
    fbp_pkg::fbp_state_e state_d;

    logic [14:0] fma_q;
    logic [31:0] fmd_q;
    logic [7:0]  usec_q;
    logic [1:0]  mask_q;
    logic [1:0]  raw_q;
    logic [15:0] re_q;
    logic [15:0] pe_q;
    logic [1:0]  dbg_q;
    logic [15:0] nv_re_q;
    logic [15:0] nv_pe_q;
    logic [1:0]  nv_dbg_q;
    logic [7:0]  us_cnt_q;
    logic [15:0] op_cnt_q;
    logic [31:0] old_q;
    logic        p1_q, p1_zero_q, p2_q, p2_zero_q, o1_q, o2_q;

    logic        fmc_wr, op_start, op_wr, op_er, op_cm, op_allowed;
    logic        refuse, proc_take, proc_block, time_done, op_end;

    ////////////////////////////////////////////////////////////////////////////
    // decode of control writes and reads

    // a control write is only taken with the key and while idle
    assign fmc_wr     = reg_wr_i && (reg_addr_i == fbp_pkg::OFS_FMC);
    assign op_start   = fmc_wr && (reg_wdata_i[31:16] == fbp_pkg::FMC_KEY) && (state_q == fbp_pkg::ST_IDLE);
    assign op_wr      = op_start && reg_wdata_i[fbp_pkg::FMC_WRITE_BIT];
    assign op_er      = op_start && reg_wdata_i[fbp_pkg::FMC_ERASE_BIT];
    assign op_cm      = op_start && reg_wdata_i[fbp_pkg::FMC_COMMIT_REQUEST_BIT_BIT];
    assign op_allowed = pe_q[fma_q[14:11]];                                   // R3
    assign refuse     = (op_wr || op_er) && !op_allowed;                      // R5 R7 R8

    // data reads of a read-protected block are answered with zeros
    assign proc_take  = rd_req_i && rd_ready_o;
    assign proc_block = !rd_fetch_i && !re_q[rd_addr_i[12:fbp_pkg::BLK_LSB]]; // R6 R8 R10

    assign time_done  = (us_cnt_q == 8'h00) && (op_cnt_q == 16'h0000);
    assign op_end     = time_done && ((state_q == fbp_pkg::ST_PROG) || (state_q == fbp_pkg::ST_ERASE)
                                      || (state_q == fbp_pkg::ST_COMMIT));

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    // next state; refused or unkeyed requests leave the sequencer idle
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            fbp_pkg::ST_IDLE:
            begin
                if (op_wr && op_allowed)
                    state_d = fbp_pkg::ST_RDOLD;
                else if (op_er && op_allowed)
                    state_d = fbp_pkg::ST_ERASE;
                else if (op_cm)
                    state_d = fbp_pkg::ST_COMMIT;
            end
            fbp_pkg::ST_RDOLD:
                state_d = fbp_pkg::ST_PROG;
            fbp_pkg::ST_PROG,
            fbp_pkg::ST_ERASE,
            fbp_pkg::ST_COMMIT:
            begin
                if (time_done)
                    state_d = fbp_pkg::ST_IDLE;
            end
            default:
                state_d = fbp_pkg::ST_IDLE;
        endcase
    end

    // state and read-port availability; reads are held off while the array is busy
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_q    <= fbp_pkg::ST_IDLE;
            rd_ready_o <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            rd_ready_o <= (state_d == fbp_pkg::ST_IDLE);
        end
    end

    // microsecond ticker reloaded from the cycles-per-microsecond value
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            us_cnt_q <= 8'h00;
            op_cnt_q <= 16'h0000;
        end
        else if (state_q == fbp_pkg::ST_IDLE || state_q == fbp_pkg::ST_RDOLD)
        begin
            us_cnt_q <= usec_q;                                               // R19
            if (state_d == fbp_pkg::ST_ERASE)
                op_cnt_q <= fbp_pkg::ERASE_US - 16'h0001;
            else if (state_d == fbp_pkg::ST_COMMIT)
                op_cnt_q <= fbp_pkg::COMMIT_US - 16'h0001;
            else
                op_cnt_q <= fbp_pkg::PROG_US - 16'h0001;
        end
        else if (us_cnt_q == 8'h00)
        begin
            us_cnt_q <= usec_q;                                               // R19
            if (op_cnt_q != 16'h0000)
                op_cnt_q <= op_cnt_q - 16'h0001;
        end
        else
        begin
            us_cnt_q <= us_cnt_q - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array access

    // one port for processor reads, old-word reads, programs and erases
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            arr_rd_o    <= 1'b0;
            arr_wr_o    <= 1'b0;
            arr_erase_o <= 1'b0;
            arr_addr_o  <= 13'h0000;
            arr_wdata_o <= 32'h00000000;
        end
        else
        begin
            arr_rd_o    <= proc_take || (state_q == fbp_pkg::ST_RDOLD);
            arr_wr_o    <= (state_q == fbp_pkg::ST_PROG) && time_done;
            arr_erase_o <= (state_q == fbp_pkg::ST_ERASE) && time_done;      // R1
            // programming can only clear bits, never set them
            arr_wdata_o <= fmd_q & old_q;                                     // R2
            if (proc_take)
                arr_addr_o <= rd_addr_i;
            else if (state_q == fbp_pkg::ST_ERASE)
                arr_addr_o <= {fma_q[14:10], 8'h00};                         // R1
            else if (state_q != fbp_pkg::ST_IDLE)
                arr_addr_o <= fma_q[14:2];
        end
    end

    // read pipelines: array data stand one cycle after the read strobe
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            p1_q      <= 1'b0;
            p1_zero_q <= 1'b0;
            p2_q      <= 1'b0;
            p2_zero_q <= 1'b0;
            o1_q      <= 1'b0;
            o2_q      <= 1'b0;
            old_q     <= 32'h00000000;
            rd_valid_o <= 1'b0;
            rd_data_o <= 32'h00000000;
        end
        else
        begin
            p1_q      <= proc_take;
            p1_zero_q <= proc_block;
            p2_q      <= p1_q;
            p2_zero_q <= p1_zero_q;
            o1_q      <= (state_q == fbp_pkg::ST_RDOLD);
            o2_q      <= o1_q;
            if (o2_q)
                old_q <= arr_rdata_i;
            rd_valid_o <= p2_q;
            rd_data_o <= (p2_q && !p2_zero_q) ? arr_rdata_i : 32'h00000000;   // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile copies

    // committed bits only ever go from one to zero
    always_ff @(posedge mclk_i)
    begin
        if (!factory_rst_n_i)
        begin
            nv_re_q  <= fbp_pkg::BLK_FACTORY;                                 // R11
            nv_pe_q  <= fbp_pkg::BLK_FACTORY;                                 // R11
            nv_dbg_q <= fbp_pkg::DBG_FACTORY;
        end
        else if ((state_q == fbp_pkg::ST_COMMIT) && time_done)
        begin
            if (fma_q == fbp_pkg::DBG_COMMIT_ADR)
            begin
                nv_re_q <= nv_re_q & re_q;                                    // R22
                if (dbg_q != fbp_pkg::DBG_EN)
                    nv_dbg_q <= 2'h0;                                         // R15
            end
            else if (fma_q[0])
                nv_pe_q <= nv_pe_q & pe_q;                                    // R21
            else
                nv_re_q <= nv_re_q & re_q;                                    // R21
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // working policy bits and debug enable

    // power-on reset restores the committed values; writes act at once
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            re_q     <= nv_re_q;                                              // R13 R24
            pe_q     <= nv_pe_q;                                              // R13 R24
            dbg_q    <= nv_dbg_q;                                             // R24
            dap_en_o <= (nv_dbg_q == fbp_pkg::DBG_EN);                        // R14 R16
        end
        else if (reg_wr_i && reg_addr_i == fbp_pkg::OFS_RE)
        begin
            re_q  <= reg_wdata_i[15:0] & nv_re_q;                             // R4 R12
            // a committed cleared field cannot be brought back to enabled
            dbg_q <= (nv_dbg_q == fbp_pkg::DBG_EN) ? reg_wdata_i[31:30] : nv_dbg_q; // R15
        end
        else if (reg_wr_i && reg_addr_i == fbp_pkg::OFS_PE)
        begin
            pe_q <= reg_wdata_i[15:0] & nv_pe_q;                              // R4 R12
        end
    end
    // dap_en_o gates the debug access port only, never the test access port  R17

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    // address, data, timing value and mask
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            fma_q  <= 15'h0000;
            fmd_q  <= 32'h00000000;
            usec_q <= fbp_pkg::USEC_RST;                                      // R20
            mask_q <= 2'h0;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == fbp_pkg::OFS_FMA)
                fma_q <= reg_wdata_i[14:0];
            if (reg_addr_i == fbp_pkg::OFS_FMD)
                fmd_q <= reg_wdata_i;
            if (reg_addr_i == fbp_pkg::OFS_USEC)
                usec_q <= reg_wdata_i[7:0];                                   // R19 R20
            if (reg_addr_i == fbp_pkg::OFS_IMASK)
                mask_q <= reg_wdata_i[1:0];
        end
    end

    // sticky status; a new event in the clearing cycle survives the clear
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            raw_q <= 2'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == fbp_pkg::OFS_MISC)
                raw_q <= raw_q & ~reg_wdata_i[1:0];
            if (refuse || (proc_take && proc_block))
                raw_q[fbp_pkg::ST_VIOL_BIT] <= 1'b1;                          // R9 R10
            if (op_end)
                raw_q[fbp_pkg::ST_DONE_BIT] <= 1'b1;
            irq_o <= |(raw_q & mask_q);                                       // R9
        end
    end

    // read data stand only in the cycle after the read strobe
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 32'h00000000;
        else if (!reg_rd_i)
            reg_rdata_o <= 32'h00000000;
        else
        begin
            unique case (reg_addr_i)
                fbp_pkg::OFS_FMA:   reg_rdata_o <= {17'h00000, fma_q};
                fbp_pkg::OFS_FMD:   reg_rdata_o <= fmd_q;
                // busy bits clear when the operation ends
                fbp_pkg::OFS_FMC:   reg_rdata_o <= {28'h0000000, (state_q == fbp_pkg::ST_COMMIT), 1'b0,
                                                    (state_q == fbp_pkg::ST_ERASE),
                                                    (state_q == fbp_pkg::ST_RDOLD) || (state_q == fbp_pkg::ST_PROG)}; // R23
                fbp_pkg::OFS_RIS:   reg_rdata_o <= {30'h00000000, raw_q};
                fbp_pkg::OFS_IMASK: reg_rdata_o <= {30'h00000000, mask_q};
                fbp_pkg::OFS_MISC:  reg_rdata_o <= {30'h00000000, raw_q & mask_q};
                fbp_pkg::OFS_RE:    reg_rdata_o <= {dbg_q, 14'h0000, re_q};     // R4
                fbp_pkg::OFS_PE:    reg_rdata_o <= {16'h0000, pe_q};            // R4
                fbp_pkg::OFS_USEC:  reg_rdata_o <= {24'h000000, usec_q};
                default:            reg_rdata_o <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence blocked_read_s;
        proc_take && proc_block;
    endsequence
    sequence fetch_take_s;
        proc_take && rd_fetch_i;
    endsequence

    read_zero_a: assert property (blocked_read_s |-> ##3 (rd_valid_o && rd_data_o == 32'h00000000)) // R10
        else $error("blocked data read did not return zeros");
    fetch_ok_a: assert property (fetch_take_s |-> ##3 (rd_valid_o && rd_data_o == $past(arr_rdata_i))) // R6
        else $error("instruction fetch was not served");
    prog_block_a: assert property (refuse |=> (state_q == fbp_pkg::ST_IDLE) && raw_q[fbp_pkg::ST_VIOL_BIT]) // R9
        else $error("protected block program or erase not refused");
    prog_clear_a: assert property (arr_wr_o |-> ((arr_wdata_o & ~old_q) == 32'h00000000)) // R2
        else $error("program would set a zero bit to one");
    commit_busy_a: assert property (op_cm |=> (state_q == fbp_pkg::ST_COMMIT) [*2]) // R23
        else $error("commit did not stay busy");
    nv_down_a: assert property (disable iff (!factory_rst_n_i)
        ((nv_re_q & ~$past(nv_re_q)) == 16'h0000) && ((nv_pe_q & ~$past(nv_pe_q)) == 16'h0000)) // R12
        else $error("committed protection bit returned to one");
    dbg_perm_a: assert property (disable iff (!factory_rst_n_i)
        ($past(nv_dbg_q) != fbp_pkg::DBG_EN) |-> (nv_dbg_q != fbp_pkg::DBG_EN)) // R15
        else $error("committed debug disable was reversed");
    dap_stable_a: assert property ($changed(dap_en_o) |-> !$past(rst_n_i)) // R16
        else $error("debug enable changed outside power-on reset");
    reset_load_a: assert property ($rose(rst_n_i) |-> (re_q == nv_re_q) && (pe_q == nv_pe_q)) // R24
        else $error("working bits not loaded from committed copies");

endmodule

// file: testbench/fbp_flash_array_model.sv
// flash array model answering the protection block's array strobes
module fbp_flash_array_model (
    // clock
    input  wire logic        mclk_i,
    // array strobes and data
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic        erase_i,
    input  wire logic [12:0] addr_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [8192];
    // array leaves the factory erased
    initial
    begin
        foreach (mem[i])
            mem[i] = 32'hFFFFFFFF;
        rdata_o = 32'h0;
    end
    // answer one cycle after the strobe; between reads the line toggles so stale data never matches
    always @(posedge mclk_i)
    begin
        rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
        if (wr_i)
            mem[addr_i] <= mem[addr_i] & wdata_i;
        if (erase_i)
            for (int k = 0; k < 256; k++)
                mem[{addr_i[12:8], 8'(k)}] <= 32'hFFFFFFFF;
    end
endmodule

// file: testbench/fbp_flash_protect_tb.sv
// self-checking bench of the flash block protection logic
module fbp_flash_protect_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        factory_rst_n_i = 1'b0;
    logic [8:0]  reg_addr_i = 9'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        rd_req_i = 1'b0;
    logic        rd_fetch_i = 1'b0;
    logic [12:0] rd_addr_i = 13'h0;
    logic        rd_ready_o;
    logic        rd_valid_o;
    logic [31:0] rd_data_o;
    logic        arr_rd_o;
    logic        arr_wr_o;
    logic        arr_erase_o;
    logic [12:0] arr_addr_o;
    logic [31:0] arr_wdata_o;
    logic [31:0] arr_rdata_i;
    logic        irq_o;
    logic        dap_en_o;
    int          miscompares = 0;
    int          num_checks = 0;
    int          n;
    logic [31:0] v, d1, d2, d3;

    ////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    fbp_flash_protect dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .factory_rst_n_i(factory_rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .rd_req_i(rd_req_i), .rd_fetch_i(rd_fetch_i), .rd_addr_i(rd_addr_i),
        .rd_ready_o(rd_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .arr_rd_o(arr_rd_o),
        .arr_wr_o(arr_wr_o), .arr_erase_o(arr_erase_o), .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
        .arr_rdata_i(arr_rdata_i), .irq_o(irq_o), .dap_en_o(dap_en_o));
    fbp_flash_array_model arr (.mclk_i(mclk_i), .rd_i(arr_rd_o), .wr_i(arr_wr_o), .erase_i(arr_erase_o),
        .addr_i(arr_addr_o), .wdata_i(arr_wdata_o), .rdata_o(arr_rdata_i));

    ////////////////////////////////////////////////////////////////
    // random words and expectations
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int op_len(input int usec);
        return 20 * (usec + 1);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask
    task automatic rchk(input string w, input logic [8:0] a, input logic [31:0] e);
        rd(a, v);
        chk(w, e, v);
    endtask
    // wait for idle without touching address or data, a busy commit still reads the address
    task automatic idle_wait;
        n = 0;
        #1;
        while (rd_ready_o !== 1'b1 && n < 2000)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk("idle", 32'h1, rd_ready_o);
    endtask
    // start one operation, wait for ready, then check that the busy bits dropped; n counts cycles without ready
    task automatic op(input logic [3:0] b, input logic [31:0] d, input logic [15:0] cmd);
        wr(fbp_pkg::OFS_FMD, d);
        wr(fbp_pkg::OFS_FMA, {17'h0, b, 11'h0});
        wr(fbp_pkg::OFS_FMC, {fbp_pkg::FMC_KEY, cmd});
        idle_wait();
        rd(fbp_pkg::OFS_FMC, v);
        chk("op end", 32'h0, v & {16'h0, cmd});
    endtask
    // one word over the read path; answer stands two edges after the taking edge
    task automatic fetch(input logic [3:0] b, input logic f, output logic [31:0] d);
        for (int i = 0; i < 300 && rd_ready_o !== 1'b1; i++)
            @(posedge mclk_i);
        @(posedge mclk_i);
        rd_addr_i  <= {b, 9'h0};
        rd_fetch_i <= f;
        rd_req_i   <= 1'b1;
        @(posedge mclk_i);
        rd_req_i   <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk("rd valid", 32'h1, rd_valid_o);
        d = rd_data_o;
    endtask
    task automatic por;
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // watchdog well beyond the roughly 1400 cycles the run needs
    initial
    begin
        #400000;
        miscompares++;
        test_done();
    end

    // main sequence
    initial
    begin
        d1 = lfsr(32'hC88D);
        d2 = lfsr(d1);
        d3 = lfsr(d2);
        repeat (5) @(posedge mclk_i);
        factory_rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rchk("re rst", fbp_pkg::OFS_RE, 32'h8000FFFF);
        rchk("pe rst", fbp_pkg::OFS_PE, 32'h0000FFFF);
        rchk("usec rst", fbp_pkg::OFS_USEC, 32'h00000031);
        rchk("unmapped", 9'h100, 32'h0);
        chk("dap rst", 32'h1, dap_en_o);
        wr(fbp_pkg::OFS_USEC, 32'h1);
        op(4'h2, d1, 16'h0001);
        chk("prog len", 32'h1, n >= op_len(1) && n <= op_len(1) + 6);
        fetch(4'h2, 1'b0, v);
        chk("prog", d1, v);
        op(4'h2, d2, 16'h0001);
        fetch(4'h2, 1'b0, v);
        chk("prog and", d1 & d2, v);
        op(4'h2, 32'h0, 16'h0002);
        fetch(4'h2, 1'b0, v);
        chk("erase", 32'hFFFFFFFF, v);
        op(4'h3, d1, 16'h0001);
        wr(fbp_pkg::OFS_IMASK, 32'h1);
        wr(fbp_pkg::OFS_PE, 32'h0000FFF3);
        wr(fbp_pkg::OFS_RE, 32'h8000FFE7);
        rchk("pe wr", fbp_pkg::OFS_PE, 32'h0000FFF3);
        op(4'h2, 32'h0, 16'h0001);
        rchk("viol", fbp_pkg::OFS_RIS, 32'h3);
        chk("irq", 32'h1, irq_o);
        fetch(4'h2, 1'b0, v);
        chk("read only", 32'hFFFFFFFF, v);
        wr(fbp_pkg::OFS_MISC, 32'h1);
        @(posedge mclk_i);
        #1;
        chk("irq clr", 32'h0, irq_o);
        op(4'h3, 32'h0, 16'h0002);
        fetch(4'h3, 1'b1, v);
        chk("exec only", d1, v);
        wr(fbp_pkg::OFS_MISC, 32'h1);
        fetch(4'h3, 1'b0, v);
        chk("rd blocked", 32'h0, v);
        #1;
        chk("irq rd", 32'h1, irq_o);
        wr(fbp_pkg::OFS_MISC, 32'h1);
        op(4'h4, d3, 16'h0001);
        fetch(4'h4, 1'b1, v);
        chk("fetch only", d3, v);
        wr(fbp_pkg::OFS_FMA, 32'h0);
        wr(fbp_pkg::OFS_FMC, {fbp_pkg::FMC_KEY, 16'h0008});
        rchk("commit_request_bit busy", fbp_pkg::OFS_FMC, 32'h8);
        idle_wait();
        rchk("commit_request_bit end", fbp_pkg::OFS_FMC, 32'h0);
        por();
        rchk("pe por", fbp_pkg::OFS_PE, 32'h0000FFFF);
        rchk("re por", fbp_pkg::OFS_RE, 32'h8000FFE7);
        wr(fbp_pkg::OFS_RE, 32'h0000FFE7);
        wr(fbp_pkg::OFS_FMA, {17'h0, fbp_pkg::DBG_COMMIT_ADR});
        wr(fbp_pkg::OFS_FMC, {fbp_pkg::FMC_KEY, 16'h0008});
        idle_wait();
        chk("dap kept", 32'h1, dap_en_o);
        por();
        chk("dap off", 32'h0, dap_en_o);
        wr(fbp_pkg::OFS_RE, 32'h8000FFFF);
        rchk("dbg locked", fbp_pkg::OFS_RE, 32'h0000FFE7);
        por();
        chk("dap stays", 32'h0, dap_en_o);
        test_done();
    end
endmodule
